/* logic/pst_access.sv */
// address construction and lane steering for program space access
`timescale 1ns/1ps
`default_nettype none

module pst_access (
	// clock and reset
	input  wire logic                          CLK,
	input  wire logic                          NRST,
	// request from the core
	input  wire logic                          REQ_VALID,
	input  wire pst_pkg::pst_kind_e            REQ_KIND,
	input  wire logic                          REQ_BYTE,
	input  wire logic [pst_pkg::PC_W-1:0]      PC,
	input  wire logic [pst_pkg::DATA_W-1:0]    EA,
	input  wire logic [pst_pkg::DATA_W-1:0]    WR_DATA,
	// configuration bits
	input  wire logic [pst_pkg::PAGE_W-1:0]    TABLE_PAGE,
	input  wire logic [pst_pkg::PAGE_W-1:0]    WINDOW_PAGE,
	input  wire logic                          DATA_WINDOW_ENABLE,
	// program memory side
	output logic                               PM_REQ,
	output logic                               PM_WE,
	output logic [2:0]                         PM_LANE_WE,
	output logic [pst_pkg::PADDR_W-1:0]        PM_ADDR,
	output logic [pst_pkg::PWORD_W-1:0]        PM_WDATA,
	input  wire logic                          PM_RVALID,
	input  wire logic [pst_pkg::PWORD_W-1:0]   PM_RDATA,
	// answer to the core
	output logic                               RD_VALID,
	output logic [pst_pkg::DATA_W-1:0]         RD_DATA,
	output logic                               DATA_TO_PROG
);
	import pst_pkg::*;

	// ------------------------------------------------------------
	// address construction
	// ------------------------------------------------------------
	// no bit 23 anywhere except the table path
	function automatic logic [PADDR_W-1:0] user_clip(input logic [PADDR_W-1:0] a);
		user_clip = {1'b0, a[PADDR_W-2:0]};
	endfunction : user_clip

	function automatic logic is_table_wr(input pst_kind_e k);
		is_table_wr = (k == PST_TWR_LO) || (k == PST_TWR_HI);
	endfunction : is_table_wr

	logic                     is_win;
	logic [PADDR_W-1:0]       addr_c;
	logic [2:0]               lane_c;
	logic [PWORD_W-1:0]       wdata_c;
	logic                     rd_pend_reg;
	logic                     rd_pend_next;
	pst_kind_e                kind_reg;
	pst_kind_e                kind_next;
	logic                     bsel_reg;
	logic                     bsel_next;
	logic                     req_reg;
	logic                     req_next;
	logic                     we_reg;
	logic                     we_next;
	logic [2:0]               lane_reg;
	logic [2:0]               lane_next;
	logic [PADDR_W-1:0]       addr_reg;
	logic [PADDR_W-1:0]       addr_next;
	logic [PWORD_W-1:0]       wdata_reg;
	logic [PWORD_W-1:0]       wdata_next;
	logic                     rv_reg;
	logic                     rv_next;
	logic [DATA_W-1:0]        rd_reg;
	logic [DATA_W-1:0]        rd_next;
	logic                     win_reg;
	logic                     win_next;
	logic                     lo_byte_even_reg;
	logic                     lo_byte_even_next;

	always_comb begin
		// table ops bypass the window entirely
		is_win   = (REQ_KIND == PST_DATA) && EA[WIN_EA_BIT] && DATA_WINDOW_ENABLE;
		addr_c   = ADDR_RST;
		lane_c   = 3'h0;
		wdata_c  = {PWORD_W{1'b0}};
		unique case (REQ_KIND)
			PST_FETCH: begin
				addr_c = user_clip({1'b0, PC[PC_W-1:1], 1'b0});
			end
			PST_TRD_LO, PST_TRD_HI, PST_TWR_LO, PST_TWR_HI: begin
				// word address drops ea bit 0; it is the byte select
				addr_c = {TABLE_PAGE, EA[DATA_W-1:1], 1'b0};
			end
			PST_DATA: begin
				addr_c = user_clip({1'b0, WINDOW_PAGE, EA[WIN_OFS_W-1:0]});
			end
			default: begin
				// codes 6 and 7 are not access kinds
				addr_c = ADDR_RST;
			end
		endcase
		// write lanes: low ops touch the lsw, high ops only the msb
		unique case (REQ_KIND)
			PST_TWR_LO: begin
				lane_c  = REQ_BYTE ? (EA[0] ? 3'h2 : 3'h1) : 3'h3;
				wdata_c = {8'h00, REQ_BYTE ? {2{WR_DATA[7:0]}} : WR_DATA};
			end
			PST_TWR_HI: begin
				// odd byte of the high space is phantom, nothing written
				lane_c  = (REQ_BYTE && EA[0]) ? 3'h0 : 3'h4;
				wdata_c = {WR_DATA[7:0], 16'h0000};
			end
			default: begin
				lane_c  = 3'h0;
				wdata_c = {PWORD_W{1'b0}};
			end
		endcase
	end

	// ------------------------------------------------------------
	// request stage
	// ------------------------------------------------------------
	always_comb begin
		req_next   = REQ_VALID && (REQ_KIND != PST_DATA || is_win);
		we_next    = REQ_VALID && is_table_wr(REQ_KIND);
		lane_next  = REQ_VALID ? lane_c : 3'h0;
		addr_next  = REQ_VALID ? addr_c : addr_reg;
		wdata_next = REQ_VALID ? wdata_c : wdata_reg;
		win_next   = REQ_VALID && is_win;
		kind_next  = REQ_VALID ? REQ_KIND : kind_reg;
		bsel_next  = REQ_VALID ? (REQ_BYTE & EA[0]) : bsel_reg;
		rd_pend_next = rd_pend_reg;
		if (PM_RVALID) begin
			rd_pend_next = 1'b0;
		end
		// a new read wins over a late answer: one read outstanding only
		if (req_next && !we_next) begin
			rd_pend_next = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// read lane steering
	// ------------------------------------------------------------
	// byte answers land in the low byte, upper byte zero
	always_comb begin
		rv_next = PM_RVALID && rd_pend_reg;
		rd_next = rd_reg;
		if (PM_RVALID && rd_pend_reg) begin
			unique case (kind_reg)
				PST_TRD_LO: begin
					if (bsel_reg) begin
						rd_next = {8'h00, PM_RDATA[15:8]};
					end else if (lo_byte_even_reg) begin
						rd_next = {8'h00, PM_RDATA[7:0]};
					end else begin
						rd_next = PM_RDATA[15:0];
					end
				end
				PST_TRD_HI: begin
					rd_next = bsel_reg ? DATA_RST : {8'h00, PM_RDATA[23:16]};
				end
				default: begin
					// fetch and window return only the lsw
					rd_next = PM_RDATA[15:0];
				end
			endcase
		end
	end

	// byte low read at even select: keep only the low byte
	always_comb begin
		lo_byte_even_next = REQ_VALID ? (REQ_KIND == PST_TRD_LO && REQ_BYTE && !EA[0])
			: lo_byte_even_reg;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			req_reg          <= 1'b0;
			we_reg           <= 1'b0;
			lane_reg         <= 3'h0;
			addr_reg         <= ADDR_RST;
			wdata_reg        <= {PWORD_W{1'b0}};
			win_reg          <= 1'b0;
			kind_reg         <= PST_FETCH;
			bsel_reg         <= 1'b0;
			rd_pend_reg      <= 1'b0;
			rv_reg           <= 1'b0;
			rd_reg           <= DATA_RST;
			lo_byte_even_reg <= 1'b0;
		end else begin
			req_reg          <= req_next;
			we_reg           <= we_next;
			lane_reg         <= lane_next;
			addr_reg         <= addr_next;
			wdata_reg        <= wdata_next;
			win_reg          <= win_next;
			kind_reg         <= kind_next;
			bsel_reg         <= bsel_next;
			rd_pend_reg      <= rd_pend_next;
			rv_reg           <= rv_next;
			rd_reg           <= rd_next;
			lo_byte_even_reg <= lo_byte_even_next;
		end
	end

	assign PM_REQ       = req_reg;
	assign PM_WE        = we_reg;
	assign PM_LANE_WE   = lane_reg;
	assign PM_ADDR      = addr_reg;
	assign PM_WDATA     = wdata_reg;
	assign RD_VALID     = rv_reg;
	assign RD_DATA      = rd_reg;
	assign DATA_TO_PROG = win_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_fetch_req;
		REQ_VALID && REQ_KIND == PST_FETCH;
	endsequence

	property p_fetch_addr;
		@(posedge CLK) disable iff (!NRST)
		s_fetch_req |=> PM_REQ && PM_ADDR == {1'b0, $past(PC[22:1]), 1'b0};
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");

	property p_user_bit23;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && (REQ_KIND == PST_FETCH || REQ_KIND == PST_DATA) |=> !PM_ADDR[23];
	endproperty
	a_user_bit23: assert property (p_user_bit23) else $error("user access set bit 23");

	property p_table_addr;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && (REQ_KIND == PST_TRD_LO || REQ_KIND == PST_TRD_HI) |=>
			PM_ADDR[23:16] == $past(TABLE_PAGE) && PM_ADDR[15:1] == $past(EA[15:1]);
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("table address wrong");

	property p_win_addr;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && REQ_KIND == PST_DATA && EA[15] && DATA_WINDOW_ENABLE |=>
			PM_REQ && DATA_TO_PROG && PM_ADDR == {1'b0, $past(WINDOW_PAGE), $past(EA[14:0])};
	endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");

	property p_win_gate;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && REQ_KIND == PST_DATA && !(EA[15] && DATA_WINDOW_ENABLE) |=> !PM_REQ;
	endproperty
	a_win_gate: assert property (p_win_gate) else $error("window opened without enable");

	property p_hi_word;
		@(posedge CLK) disable iff (!NRST)
		PM_RVALID && rd_pend_reg && kind_reg == PST_TRD_HI && !bsel_reg |=>
			RD_VALID && RD_DATA == {8'h00, $past(PM_RDATA[23:16])};
	endproperty
	a_hi_word: assert property (p_hi_word) else $error("high read data wrong");

	property p_hi_odd;
		@(posedge CLK) disable iff (!NRST)
		PM_RVALID && rd_pend_reg && kind_reg == PST_TRD_HI && bsel_reg |=> RD_DATA == 16'h0000;
	endproperty
	a_hi_odd: assert property (p_hi_odd) else $error("high odd byte not zero");

	property p_lo_word;
		@(posedge CLK) disable iff (!NRST)
		PM_RVALID && rd_pend_reg && kind_reg == PST_TRD_LO && !bsel_reg && !lo_byte_even_reg
			|=> RD_DATA == $past(PM_RDATA[15:0]);
	endproperty
	a_lo_word: assert property (p_lo_word) else $error("low read data wrong");

	property p_lo_odd;
		@(posedge CLK) disable iff (!NRST)
		PM_RVALID && rd_pend_reg && kind_reg == PST_TRD_LO && bsel_reg
			|=> RD_DATA == {8'h00, $past(PM_RDATA[15:8])};
	endproperty
	a_lo_odd: assert property (p_lo_odd) else $error("low odd byte wrong");

	property p_lo_even;
		@(posedge CLK) disable iff (!NRST)
		PM_RVALID && rd_pend_reg && kind_reg == PST_TRD_LO && lo_byte_even_reg
			|=> RD_DATA == {8'h00, $past(PM_RDATA[7:0])};
	endproperty
	a_lo_even: assert property (p_lo_even) else $error("low even byte wrong");

	property p_fetch_range;
		@(posedge CLK) disable iff (!NRST)
		s_fetch_req |=> PM_ADDR <= USER_TOP;
	endproperty
	a_fetch_range: assert property (p_fetch_range) else $error("fetch outside user range");

	// writes are not covered by the table read address check
	property p_cfg_space;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && is_table_wr(REQ_KIND) |=>
			PM_WE && PM_ADDR[23] == $past(TABLE_PAGE[CFG_SEL_BIT]);
	endproperty
	a_cfg_space: assert property (p_cfg_space) else $error("table write space wrong");

	property p_lo_lane;
		@(posedge CLK) disable iff (!NRST)
		REQ_VALID && REQ_KIND == PST_TWR_LO |=> PM_WE && !PM_LANE_WE[2];
	endproperty
	a_lo_lane: assert property (p_lo_lane) else $error("low write hit upper byte");
endmodule : pst_access

`default_nettype wire

/* logic/pst_pkg.sv */
// constants for the program space table access block
package pst_pkg;
	localparam int PADDR_W        = 24;
	localparam int PWORD_W        = 24;
	localparam int DATA_W         = 16;
	localparam int PC_W           = 23;
	localparam int PAGE_W         = 8;
	localparam int CFG_SEL_BIT    = 7;
	localparam int WIN_EA_BIT     = 15;
	localparam int WIN_OFS_W      = 15;
	localparam logic [PADDR_W-1:0] USER_TOP   = 24'h7FFFFE;
	localparam logic [PADDR_W-1:0] WORD_STEP  = 24'h000002;
	localparam logic [PADDR_W-1:0] ADDR_RST   = 24'h000000;
	localparam logic [DATA_W-1:0]  DATA_RST   = 16'h0000;
	localparam logic [PAGE_W-1:0]  PAGE_RST   = 8'h00;
	localparam int WINDOW_WORDS   = 16384;
	// access kinds from the core
	typedef enum logic [2:0] {
		PST_FETCH,
		PST_TRD_LO,
		PST_TRD_HI,
		PST_TWR_LO,
		PST_TWR_HI,
		PST_DATA
	} pst_kind_e;
endpackage : pst_pkg

/* bench/pst_mem_model.sv */
// program memory model answering reads after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module pst_mem_model (
	// clock
	input  wire logic        CLK,
	// access from the block, and the answer delay
	input  wire logic        PM_REQ,
	input  wire logic        PM_WE,
	input  wire logic [23:0] PM_ADDR,
	input  wire logic [3:0]  DLY,
	// answer
	output logic             PM_RVALID,
	output logic [23:0]      PM_RDATA
);
	logic [23:0] a_reg;
	int          n_reg = -1;
	initial begin
		PM_RVALID = 1'b0;
		PM_RDATA  = 24'h000000;
	end
	always @(posedge CLK) begin
		PM_RVALID <= 1'b0;
		// stale data toggles so it never passes for an answer
		PM_RDATA  <= ~PM_RDATA;
		if (PM_REQ && !PM_WE) begin
			a_reg <= PM_ADDR;
			n_reg <= int'(DLY);
		end else if (n_reg > 0) begin
			n_reg <= n_reg - 1;
		end else if (n_reg == 0) begin
			PM_RVALID <= 1'b1;
			PM_RDATA  <= {8'hC3 ^ a_reg[8:1], a_reg[16:1] ^ 16'hA55A};
			n_reg     <= -1;
		end
	end
endmodule : pst_mem_model
`default_nettype wire

/* bench/test_pst_access.sv */
// self-checking testbench for program space table access
`timescale 1ns/1ps
`default_nettype none
module test_pst_access;
	import pst_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_byte = 1'b0, win_en = 1'b0;
	logic pm_req, pm_we, pm_rvalid, rd_valid, to_prog;
	logic [2:0] pm_lane_we;
	logic [3:0] dly = 4'h0;
	logic [7:0] tpage = 8'h00, wpage = 8'h00;
	logic [15:0] ea = 16'h0000, wr_data = 16'h0000, rd_data;
	logic [22:0] pc = 23'h000000;
	logic [23:0] pm_addr, pm_wdata, pm_rdata;
	pst_kind_e kind = PST_FETCH;
	int num_errors = 0, cmp_count = 0;
	pst_access dut (.CLK(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_KIND(kind),
		.REQ_BYTE(req_byte), .PC(pc), .EA(ea), .WR_DATA(wr_data), .TABLE_PAGE(tpage),
		.WINDOW_PAGE(wpage), .DATA_WINDOW_ENABLE(win_en), .PM_REQ(pm_req), .PM_WE(pm_we),
		.PM_LANE_WE(pm_lane_we), .PM_ADDR(pm_addr), .PM_WDATA(pm_wdata),
		.PM_RVALID(pm_rvalid), .PM_RDATA(pm_rdata), .RD_VALID(rd_valid),
		.RD_DATA(rd_data), .DATA_TO_PROG(to_prog));
	pst_mem_model mem (.CLK(clk), .PM_REQ(pm_req), .PM_WE(pm_we), .PM_ADDR(pm_addr),
		.DLY(dly), .PM_RVALID(pm_rvalid), .PM_RDATA(pm_rdata));
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic summarize();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [23:0] pw(input logic [23:0] a);
		return {8'hC3 ^ a[8:1], a[16:1] ^ 16'hA55A};
	endfunction : pw
	// one request; returns 1 ns after the taking edge
	task automatic issue(input pst_kind_e k, input logic b, input logic [15:0] e);
		kind = k;
		req_byte = b;
		ea = e;
		req_valid = 1'b1;
		@(posedge clk);
		#1 req_valid = 1'b0;
	endtask : issue
	task automatic rd(input pst_kind_e k, input logic b, input logic [15:0] e,
		input logic [23:0] adr, input logic [15:0] dat, input logic win);
		logic ok;
		ok = 1'b0;
		issue(k, b, e);
		chk(pm_req, 1'b1);
		chk(pm_addr, adr);
		chk(to_prog, win);
		for (int i = 0; i < 30 && !ok; i++) begin
			@(posedge clk);
			#1 ok = rd_valid;
		end
		if (!ok) begin
			num_errors++;
			summarize();
		end else begin
			chk(rd_data, dat);
		end
	endtask : rd
	task automatic t_fetch();
		pc = 23'h7FFFFF;
		tpage = 8'h80;
		win_en = 1'b1;
		rd(PST_FETCH, 1'b0, 16'hFFFF, 24'h7FFFFE, pw(24'h7FFFFE), 1'b0);
		pc = 23'h000003;
		rd(PST_FETCH, 1'b0, 16'h0000, 24'h000002, pw(24'h000002), 1'b0);
	endtask : t_fetch
	// table reads with the window open and ea bit 15 set: window must stay out
	task automatic t_tables();
		logic [23:0] a, w;
		logic [15:0] e;
		for (int i = 0; i < 8; i++) begin
			tpage = i[0] ? 8'h80 : 8'h12;
			e = {1'b1, 14'h2B3C, i[0]};
			a = {tpage, e[15:1], 1'b0};
			w = pw(a);
			if (i < 4) rd(PST_TRD_LO, i[1], e, a, i[1] ? {8'h00, i[0] ? w[15:8] : w[7:0]}
				: w[15:0], 1'b0);
			else rd(PST_TRD_HI, i[1], e, a, (i[1] && i[0]) ? 16'h0000
				: {8'h00, w[23:16]}, 1'b0);
		end
	endtask : t_tables
	task automatic t_writes();
		logic [2:0] lanes [4] = '{3'b011, 3'b001, 3'b100, 3'b000};
		tpage = 8'h81;
		wr_data = 16'h9A7E;
		for (int i = 0; i < 4; i++) begin
			issue(i < 2 ? PST_TWR_LO : PST_TWR_HI, i[0], {15'h1234, i[0]});
			chk(pm_we, 1'b1);
			chk(pm_addr, 24'h812468);
			chk(pm_lane_we, (i == 1) ? 3'b010 : lanes[i]);
			chk(i < 2 ? pm_wdata[15:0] : pm_wdata[23:16], i == 0 ? wr_data
				: (i == 1 ? 16'h7E7E : 16'h007E));
			@(posedge clk);
			#1;
		end
	endtask : t_writes
	task automatic t_window();
		wpage = 8'hA5;
		win_en = 1'b1;
		rd(PST_DATA, 1'b0, 16'hFFFE, 24'h52FFFE, pw(24'h52FFFE)
			, 1'b1);
		for (int i = 0; i < 2; i++) begin
			win_en = i[0];
			issue(PST_DATA, 1'b0, i[0] ? 16'h7FFE : 16'hFFFE);
			repeat (3) begin
				chk(pm_req, 1'b0);
				@(posedge clk);
				#1;
			end
		end
	endtask : t_window
	initial begin
		repeat (2) @(posedge clk);
		#1 chk({pm_req, rd_valid, to_prog}, 3'b000);
		chk(pm_addr, ADDR_RST);
		nrst = 1'b1;
		@(posedge clk);
		#1 t_fetch();
		for (int d = 0; d < 2; d++) begin
			dly = d[0] ? 4'h9 : 4'h0;
			t_tables();
		end
		t_writes();
		t_window();
		summarize();
	end
endmodule : test_pst_access
`default_nettype wire
